// ### stop_supervisor_pkg.sv
// Constants, encodings and carrier types of the stop-mode power supervisor
package stop_supervisor_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_CTRL       = 12'h000;
	localparam logic [11:0] OFF_WAKE       = 12'h004;
	localparam logic [11:0] OFF_STATUS     = 12'h008;
	localparam logic [11:0] OFF_MASK       = 12'h00C;
	localparam logic [11:0] OFF_STATE      = 12'h010;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_MON_OFF    = 0;
	localparam int CTRL_TRIP_LSB   = 1;
	localparam int CTRL_IVAL_LSB   = 3;
	localparam int CTRL_STOP_REQ   = 8;
	localparam int WAKE_W          = 16;
	localparam int EV_IO           = 0;
	localparam int EV_WARN         = 1;
	localparam int EV_TIMER        = 2;
	localparam int EV_PFRST        = 3;
	localparam int EV_N            = 4;
	localparam int STATE_LSB       = 8;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic       MON_OFF_RESET   = 1'b1;
	localparam logic [1:0] TRIP_RESET      = 2'h0;
	localparam logic [1:0] IVAL_RESET      = 2'h0;
	// Trip select: 00 1.67 V, 01 1.9 V, 10 2.5 V, 11 2.7 V nominal
	localparam logic [1:0] TRIP_1V67       = 2'h0;
	localparam logic [1:0] TRIP_1V9        = 2'h1;
	localparam logic [1:0] TRIP_2V5        = 2'h2;
	localparam logic [1:0] TRIP_2V7        = 2'h3;
	// Sampling interval: continuous, 2^11, 2^12, 2^13 ring clocks
	localparam logic [1:0] IVAL_CONT       = 2'h0;
	localparam logic [1:0] IVAL_2K         = 2'h1;
	localparam logic [1:0] IVAL_4K         = 2'h2;
	localparam logic [1:0] IVAL_8K         = 2'h3;
	localparam int         IVAL_W          = 13;
	localparam logic [IVAL_W-1:0] IVAL_END_2K = 13'h07FF;
	localparam logic [IVAL_W-1:0] IVAL_END_4K = 13'h0FFF;
	localparam logic [IVAL_W-1:0] IVAL_END_8K = 13'h1FFF;
	localparam logic [1:0] BURST_TICKS     = 2'h2;
	localparam logic [15:0] BOOT_ROM_ADDR  = 16'h8000;
	localparam logic [15:0] BOOT_APP_ADDR  = 16'h0000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 10;
	localparam int RING_FREQ_HZ        = 8000;
	localparam int WAKE_STEP_US        = 125;
	localparam int CRYSTAL_WARMUP_US   = 1000;
	localparam int CRYSTAL_WARMUP_CYC  =
		(CRYSTAL_WARMUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CPU_RELEASE_MAX     = 20;
	localparam int CPU_RELEASE_CYC     = CPU_RELEASE_MAX - 1;
	localparam int WARM_W              = 24;

	// ----------------------------------------------------------------
	// Synchroniser lanes
	// ----------------------------------------------------------------
	localparam int SY_IO       = 0;
	localparam int SY_EXTRST_N = 1;
	localparam int SY_WARN     = 2;
	localparam int SY_RST      = 3;
	localparam int SY_POR      = 4;
	localparam int SY_RING     = 5;
	localparam int SY_N        = 6;
	localparam logic [SY_N-1:0] SY_INIT = 6'h1E;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_POR, ST_PF_RESET, ST_PF_CONFIRM, ST_PF_WARMUP,
		ST_EXT_RESET, ST_RUN, ST_STOP, ST_WARMUP
	} sup_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic below_warn;
		logic below_reset;
		logic below_por;
	} comparator_t;

	typedef struct packed {
		logic       regulator_en;
		logic       crystal_en;
		logic       monitor_en;
		logic       sram_retain;
		logic       cpu_halt;
		logic       cpu_reset_n;
		logic [1:0] warn_trip_select;
		logic [15:0] boot_addr;
	} power_ctl_t;

endpackage : stop_supervisor_pkg

// ### stop_supervisor.sv
// Stop-mode, wake-up timer and power-fail reset sequencer with APB registers
`timescale 1ns/10ps
`default_nettype none

module stop_supervisor
	import stop_supervisor_pkg::*;
#(
	parameter int WARMUP_CYCLES = CRYSTAL_WARMUP_CYC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire apb_req_t    apb_req,
	output var  apb_rsp_t    apb_rsp,
	// Asynchronous inputs
	input  wire logic        ring_clk,
	input  wire logic        io_wake,
	input  wire logic        ext_reset_n,
	input  wire comparator_t comparator,
	// Same-clock inputs
	input  wire logic        wdt_reset,
	// Power and CPU control
	output var  power_ctl_t  power_ctl,
	output logic             irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [SY_N-1:0]   sync1;
		logic [SY_N-1:0]   sync2;
		logic              ring_prev;
		sup_state_t        state;
		logic              mon_off;
		logic [1:0]        trip;
		logic [1:0]        ival;
		logic [WAKE_W-1:0] wake_period;
		logic [WAKE_W-1:0] wake_cnt;
		logic [IVAL_W-1:0] ival_cnt;
		logic [1:0]        burst_cnt;
		logic              burst_low;
		logic [WARM_W-1:0] warm_cnt;
		logic [EV_N-1:0]   status;
		logic [EV_N-1:0]   mask;
		logic              boot_rom;
		logic [31:0]       prdata;
		logic              pslverr;
	} regs_t;

	localparam regs_t REGS_RESET = '{
		sync1: SY_INIT, sync2: SY_INIT, state: ST_POR,
		mon_off: MON_OFF_RESET, trip: TRIP_RESET, ival: IVAL_RESET,
		default: '0};

	localparam logic [WARM_W-1:0] WARM_LAST =
		WARM_W'(WARMUP_CYCLES - 1);
	localparam logic [WARM_W-1:0] RELEASE_LAST =
		WARM_W'(CPU_RELEASE_CYC - 1);

	regs_t s_q;
	regs_t s_d;

	logic              tick;
	logic              s_io;
	logic              s_ext;
	logic              s_warn;
	logic              s_rst;
	logic              s_por;
	logic              setup;
	logic              wr;
	logic              rd_status;
	logic              stop_req;
	logic [EV_N-1:0]   ev;
	logic [IVAL_W-1:0] ival_end;
	logic [31:0]       rd_val;
	logic              rd_err;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		ev = '0;
		stop_req = 1'b0;
		// Two-stage synchronisers
		s_d.sync1 = {ring_clk, comparator.below_por,
			comparator.below_reset, comparator.below_warn,
			ext_reset_n, io_wake};
		s_d.sync2 = s_q.sync1;
		s_d.ring_prev = s_q.sync2[SY_RING];
		tick   = s_q.sync2[SY_RING] & ~s_q.ring_prev;
		s_io   = s_q.sync2[SY_IO];
		s_ext  = ~s_q.sync2[SY_EXTRST_N] | wdt_reset;
		s_warn = s_q.sync2[SY_WARN];
		s_rst  = s_q.sync2[SY_RST];
		s_por  = s_q.sync2[SY_POR];

		unique case (s_q.ival)
			IVAL_CONT: ival_end = '0;
			IVAL_2K:   ival_end = IVAL_END_2K;
			IVAL_4K:   ival_end = IVAL_END_4K;
			IVAL_8K:   ival_end = IVAL_END_8K;
		endcase

		// APB decode
		setup = apb_req.psel & ~apb_req.penable;
		wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
		rd_status = apb_req.psel & apb_req.penable & ~apb_req.pwrite &
			(apb_req.paddr == OFF_STATUS);
		rd_err = 1'b0;
		rd_val = '0;
		unique case (apb_req.paddr)
			OFF_CTRL: begin
				rd_val[CTRL_MON_OFF] = s_q.mon_off;
				rd_val[CTRL_TRIP_LSB +: 2] = s_q.trip;
				rd_val[CTRL_IVAL_LSB +: 2] = s_q.ival;
			end
			OFF_WAKE:   rd_val[WAKE_W-1:0] = s_q.wake_period;
			OFF_STATUS: rd_val[EV_N-1:0] = s_q.status;
			OFF_MASK:   rd_val[EV_N-1:0] = s_q.mask;
			OFF_STATE: begin
				rd_val[EV_N-1:0] = {power_ctl.regulator_en,
					power_ctl.crystal_en, power_ctl.monitor_en,
					power_ctl.cpu_reset_n};
				rd_val[STATE_LSB +: 3] = s_q.state;
			end
			default: rd_err = 1'b1;
		endcase
		if (setup) begin
			s_d.prdata = rd_val;
			s_d.pslverr = rd_err;
		end
		if (wr) begin
			unique case (apb_req.paddr)
				OFF_CTRL: begin
					s_d.mon_off = apb_req.pwdata[CTRL_MON_OFF];
					s_d.trip = apb_req.pwdata[CTRL_TRIP_LSB +: 2];
					s_d.ival = apb_req.pwdata[CTRL_IVAL_LSB +: 2];
					stop_req = apb_req.pwdata[CTRL_STOP_REQ];
				end
				OFF_WAKE: s_d.wake_period = apb_req.pwdata[WAKE_W-1:0];
				OFF_MASK: s_d.mask = apb_req.pwdata[EV_N-1:0];
				default: ;
			endcase
		end

		// Sequencer
		unique case (s_q.state)
			ST_POR: begin
				if (!s_por) begin
					s_d.state = ST_PF_RESET;
					s_d.ival_cnt = '0;
					s_d.burst_cnt = '0;
				end
			end
			ST_PF_RESET: begin
				if (tick) begin
					if (s_q.burst_cnt != '0) begin
						s_d.burst_cnt = s_q.burst_cnt - 2'h1;
						s_d.burst_low = s_q.burst_low | s_rst;
						if (s_q.burst_cnt == 2'h1) begin
							s_d.ival_cnt = '0;
							if (!(s_q.burst_low | s_rst))
								s_d.state = ST_PF_CONFIRM;
						end
					end else if (s_q.ival_cnt == ival_end) begin
						s_d.burst_cnt = BURST_TICKS;
						s_d.burst_low = 1'b0;
					end else begin
						s_d.ival_cnt = s_q.ival_cnt + 1'b1;
					end
				end
			end
			ST_PF_CONFIRM: begin
				if (tick) begin
					s_d.warm_cnt = '0;
					s_d.state = s_rst ? ST_PF_RESET : ST_PF_WARMUP;
				end
			end
			ST_PF_WARMUP: begin
				s_d.warm_cnt = s_q.warm_cnt + 1'b1;
				if (s_rst) begin
					s_d.state = ST_PF_RESET;
				end else if (s_q.warm_cnt == WARM_LAST) begin
					s_d.boot_rom = 1'b1;
					s_d.state = ST_RUN;
				end
			end
			ST_EXT_RESET: begin
				if (s_ext) begin
					s_d.warm_cnt = '0;
				end else if (s_q.warm_cnt == RELEASE_LAST) begin
					s_d.boot_rom = 1'b0;
					s_d.state = ST_RUN;
				end else begin
					s_d.warm_cnt = s_q.warm_cnt + 1'b1;
				end
			end
			ST_RUN: begin
				if (s_rst) begin
					ev[EV_PFRST] = 1'b1;
					s_d.state = ST_PF_RESET;
					s_d.ival_cnt = '0;
					s_d.burst_cnt = '0;
				end else if (s_ext) begin
					s_d.warm_cnt = '0;
					s_d.state = ST_EXT_RESET;
				end else if (stop_req) begin
					s_d.wake_cnt = '0;
					s_d.state = ST_STOP;
				end
				ev[EV_WARN] = s_warn & ~s_rst;
			end
			ST_STOP: begin
				s_d.warm_cnt = '0;
				if (tick && s_q.wake_period != '0)
					s_d.wake_cnt = s_q.wake_cnt + 1'b1;
				if (tick && s_q.wake_period != '0 &&
					s_q.wake_cnt + 1'b1 == s_q.wake_period)
					ev[EV_TIMER] = 1'b1;
				ev[EV_IO] = s_io;
				if (!s_q.mon_off && tick) begin
					ev[EV_PFRST] = s_rst;
					ev[EV_WARN] = s_warn & ~s_rst;
				end
				if (ev[EV_PFRST]) begin
					s_d.state = ST_PF_RESET;
					s_d.ival_cnt = '0;
					s_d.burst_cnt = '0;
				end else if (ev[EV_IO] | ev[EV_WARN] | ev[EV_TIMER]) begin
					s_d.state = ST_WARMUP;
				end
			end
			ST_WARMUP: begin
				s_d.warm_cnt = s_q.warm_cnt + 1'b1;
				if (s_q.warm_cnt == WARM_LAST)
					s_d.state = ST_RUN;
			end
		endcase
		if (s_q.state == ST_PF_RESET && s_d.state == ST_PF_RESET &&
			s_q.burst_cnt == '0 && s_d.burst_cnt == '0 &&
			s_q.ival == IVAL_CONT && tick) begin
			s_d.burst_cnt = BURST_TICKS;
			s_d.burst_low = 1'b0;
		end
		if (s_por) begin
			s_d.state = ST_POR;
			s_d.boot_rom = 1'b0;
		end

		// Sticky events; a read clears only the bits it returned
		s_d.status = (s_q.status &
			~(s_q.prdata[EV_N-1:0] & {EV_N{rd_status}})) | ev;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s_q <= REGS_RESET;
		else
			s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		power_ctl.warn_trip_select = s_q.trip;
		power_ctl.boot_addr = s_q.boot_rom ? BOOT_ROM_ADDR : BOOT_APP_ADDR;
		power_ctl.sram_retain = s_q.state != ST_POR;
		power_ctl.regulator_en = 1'b0;
		power_ctl.crystal_en = 1'b0;
		power_ctl.monitor_en = 1'b0;
		power_ctl.cpu_halt = 1'b0;
		power_ctl.cpu_reset_n = 1'b0;
		unique case (s_q.state)
			ST_POR: ;
			ST_PF_RESET: begin
				power_ctl.monitor_en = (s_q.ival == IVAL_CONT) ||
					(s_q.burst_cnt != '0);
			end
			ST_PF_CONFIRM: power_ctl.monitor_en = 1'b1;
			ST_PF_WARMUP: begin
				power_ctl.monitor_en = 1'b1;
				power_ctl.regulator_en = 1'b1;
				power_ctl.crystal_en = 1'b1;
			end
			ST_EXT_RESET: begin
				power_ctl.monitor_en = 1'b1;
				power_ctl.regulator_en = 1'b1;
				power_ctl.crystal_en = 1'b1;
			end
			ST_RUN: begin
				power_ctl.monitor_en = 1'b1;
				power_ctl.regulator_en = 1'b1;
				power_ctl.crystal_en = 1'b1;
				power_ctl.cpu_reset_n = 1'b1;
			end
			ST_STOP: begin
				power_ctl.cpu_halt = 1'b1;
				power_ctl.cpu_reset_n = 1'b1;
				power_ctl.monitor_en = ~s_q.mon_off;
			end
			ST_WARMUP: begin
				power_ctl.cpu_halt = 1'b1;
				power_ctl.cpu_reset_n = 1'b1;
				power_ctl.monitor_en = 1'b1;
				power_ctl.regulator_en = 1'b1;
				power_ctl.crystal_en = 1'b1;
			end
		endcase
		apb_rsp.prdata = s_q.prdata;
		apb_rsp.pready = 1'b1;
		apb_rsp.pslverr = s_q.pslverr & apb_req.psel & apb_req.penable;
		irq = |(s_q.status & s_q.mask);
	end

endmodule : stop_supervisor

`default_nettype wire

// ### supply_ring_model.sv
// Supply comparators and free-running ring oscillator facing the supervisor
`timescale 1ns/10ps
`default_nettype none

module supply_ring_model
	import stop_supervisor_pkg::*;
(
	// Supply level: 0 good, 1 warning, 2 reset, 3 power-on
	input  wire logic [1:0]  level,
	// Towards the supervisor
	output var  logic        ring_clk,
	output var  comparator_t comparator
);

	// Ring runs free, phase unrelated to pclk
	initial ring_clk = 1'b0;
	always #80.3 ring_clk = ~ring_clk;

	// Thresholds nest: a lower supply trips every higher comparator
	always_comb begin
		comparator.below_warn  = (level >= 2'h1);
		comparator.below_reset = (level >= 2'h2);
		comparator.below_por   = (level == 2'h3);
	end

endmodule : supply_ring_model

`default_nettype wire

// ### stop_supervisor_monitor.sv
// Assertion checker bound to the stop-mode power supervisor
`timescale 1ns/10ps
`default_nettype none

module stop_supervisor_monitor
	import stop_supervisor_pkg::*;
#(
	parameter int WARMUP_CYCLES = 8
) (
	// Watched ports
	input wire logic        pclk,
	input wire logic        presetn,
	input wire apb_req_t    apb_req,
	input wire apb_rsp_t    apb_rsp,
	input wire logic        ring_clk,
	input wire logic        io_wake,
	input wire logic        ext_reset_n,
	input wire comparator_t comparator,
	input wire logic        wdt_reset,
	input wire power_ctl_t  power_ctl,
	input wire logic        irq
);

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Cycles spent halted with the crystal running
	logic [23:0] warm_q;
	logic [23:0] warm_d;
	always_comb begin
		warm_d = '0;
		if (power_ctl.cpu_halt && power_ctl.crystal_en) begin
			warm_d = warm_q + 24'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warm_q <= '0;
		end else begin
			warm_q <= warm_d;
		end
	end

	AST_HALT_KEEPS_STATE: assert property (
		power_ctl.cpu_halt |-> power_ctl.sram_retain && power_ctl.cpu_reset_n)
		else $error("halted cpu lost retention");
	AST_RUN_MONITOR_ON: assert property (
		!power_ctl.cpu_halt && power_ctl.cpu_reset_n |-> power_ctl.monitor_en)
		else $error("monitor off while running");
	AST_TRIP_FOLLOWS_WRITE: assert property (
		apb_req.psel && apb_req.penable && apb_req.pwrite
		&& apb_req.paddr == OFF_CTRL
		|=> power_ctl.warn_trip_select
		== $past(apb_req.pwdata[CTRL_TRIP_LSB +: 2]))
		else $error("trip select not taken");
	AST_WDT_KEEPS_POWER: assert property (
		wdt_reset && power_ctl.cpu_reset_n && !power_ctl.cpu_halt
		&& !comparator.below_reset |-> ##[1:2] (!power_ctl.cpu_reset_n
		&& power_ctl.regulator_en && power_ctl.crystal_en
		&& power_ctl.monitor_en))
		else $error("watchdog reset dropped power");
	AST_WDT_RELEASE: assert property (
		$fell(wdt_reset) && !power_ctl.cpu_reset_n && power_ctl.monitor_en
		&& ext_reset_n |-> ##[1:20] power_ctl.cpu_reset_n)
		else $error("cpu release too late");
	AST_STOP_ENTRY: assert property (
		$rose(power_ctl.cpu_halt) |-> !power_ctl.regulator_en
		&& !power_ctl.crystal_en && power_ctl.sram_retain)
		else $error("stop entry left supplies on");
	AST_WARMUP_LENGTH: assert property (
		$fell(power_ctl.cpu_halt) && power_ctl.cpu_reset_n
		|-> warm_q >= WARMUP_CYCLES)
		else $error("stop exit before warmup");
	AST_POR_ALL_OFF: assert property (
		comparator.below_por [*4] |-> !power_ctl.regulator_en
		&& !power_ctl.crystal_en && !power_ctl.monitor_en
		&& !power_ctl.cpu_reset_n)
		else $error("below power-on level not held");

endmodule : stop_supervisor_monitor

bind stop_supervisor stop_supervisor_monitor #(
	.WARMUP_CYCLES(WARMUP_CYCLES)
) i_stop_supervisor_monitor (
	.pclk, .presetn, .apb_req, .apb_rsp, .ring_clk, .io_wake,
	.ext_reset_n, .comparator, .wdt_reset, .power_ctl, .irq
);

`default_nettype wire

// ### stop_supervisor_tb_top.sv
// Self-checking testbench of the stop-mode power supervisor
`timescale 1ns/10ps
`default_nettype none

module stop_supervisor_tb_top;
	import stop_supervisor_pkg::*;

	logic        pclk        = 1'b0;
	logic        presetn     = 1'b0;
	apb_req_t    req         = '0;
	apb_rsp_t    rsp;
	logic        ring_clk;
	logic        io_wake     = 1'b0;
	logic        ext_reset_n = 1'b1;
	logic        wdt_reset   = 1'b0;
	logic [1:0]  level       = 2'h0;
	comparator_t comparator;
	power_ctl_t  pc;
	logic        irq;
	logic [31:0] rd;
	logic [31:0] d;
	logic        err;
	int          errors      = 0;
	int          n_checks    = 0;
	int          n;

	always #5 pclk = ~pclk;

	supply_ring_model i_supply_ring_model (
		.level(level), .ring_clk(ring_clk), .comparator(comparator));
	stop_supervisor #(.WARMUP_CYCLES(8)) i_stop_supervisor (
		.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.ring_clk(ring_clk), .io_wake(io_wake), .ext_reset_n(ext_reset_n),
		.comparator(comparator), .wdt_reset(wdt_reset), .power_ctl(pc),
		.irq(irq));

	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk

	function automatic logic [31:0] ev(input int k);
		return 32'h1 << k;
	endfunction : ev

	function automatic logic pick(input int s);
		return (s == 0) ? pc.cpu_halt : pc.cpu_reset_n;
	endfunction : pick

	// One APB transfer; answer taken at the edge pready is seen
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		logic rdy;
		rdy = 1'b0;
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, wd};
		@(posedge pclk);
		req.penable <= 1'b1;
		for (int k = 0; k < 20 && !rdy; k++) begin
			@(posedge pclk);
			rdy = (rsp.pready === 1'b1);
			rd = rsp.prdata;
			err = rsp.pslverr;
		end
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		#1;
		chk("pready", 32'h1, 32'(rdy));
		if (!rdy) close_out();
	endtask : apb

	task automatic wait_on(input int s, input logic v, input int lim = 5000);
		for (n = 0; n < lim && pick(s) !== v; n++) begin
			@(posedge pclk);
			#1;
		end
		chk("wait", 32'(v), 32'(pick(s)));
		if (pick(s) !== v) close_out();
	endtask : wait_on

	task automatic enter_stop(input logic [31:0] c);
		apb(1'b1, OFF_CTRL, c);
		wait_on(0, 1'b1);
		chk("stop regulator", 32'h0, 32'(pc.regulator_en));
		@(posedge pclk);
	endtask : enter_stop

	initial begin
		void'($urandom(37));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		wait_on(1, 1'b1);
		chk("boot", 32'h8000, 32'(pc.boot_addr));
		apb(1'b0, OFF_CTRL, 32'h0);
		chk("ctrl reset", 32'h1, rd);
		apb(1'b0, 12'h014, 32'h0);
		chk("unmapped", 32'h1, 32'(err));
		apb(1'b0, OFF_STATUS, 32'h0);
		for (int t = 0; t < 4; t++) begin
			d = ($urandom & 32'hFFFFFEE1) | (32'(t) << 1);
			apb(1'b1, OFF_CTRL, d);
			chk("trip", 32'(t), 32'(pc.warn_trip_select));
			apb(1'b0, OFF_CTRL, 32'h0);
			chk("ctrl", d & 32'h1F, rd);
		end
		apb(1'b1, OFF_MASK, 32'hF);
		apb(1'b1, OFF_WAKE, 32'(1 + $urandom_range(3)));
		enter_stop(32'h101);
		wait_on(0, 1'b0);
		chk("timer irq", 32'h1, 32'(irq));
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("timer status", ev(EV_TIMER), rd);
		repeat (2) @(posedge pclk);
		#1;
		chk("irq clear", 32'h0, 32'(irq));
		apb(1'b1, OFF_MASK, 32'h0);
		apb(1'b1, OFF_WAKE, 32'h0);
		@(posedge pclk);
		level <= 2'h1;
		repeat (6) @(posedge pclk);
		level <= 2'h0;
		#1;
		chk("masked irq", 32'h0, 32'(irq));
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("warn status", ev(EV_WARN), rd);
		apb(1'b1, OFF_MASK, 32'hF);
		enter_stop(32'h101);
		level <= 2'h2;
		repeat (80) @(posedge pclk);
		level <= 2'h0;
		#1;
		chk("stop held", 32'h3, {30'h0, pc.cpu_halt, pc.cpu_reset_n});
		repeat (4) @(posedge pclk);
		io_wake <= 1'b1;
		wait_on(0, 1'b0);
		@(posedge pclk);
		io_wake <= 1'b0;
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("io status", ev(EV_IO), rd);
		enter_stop(32'h100);
		// Short dip placed between two ring ticks
		@(posedge ring_clk);
		repeat (2) @(posedge pclk);
		level <= 2'h1;
		repeat (4) @(posedge pclk);
		level <= 2'h0;
		repeat (20) @(posedge pclk);
		#1;
		chk("dip held", 32'h1, 32'(pc.cpu_halt));
		@(posedge pclk);
		level <= 2'h1;
		wait_on(0, 1'b0);
		chk("warn crystal", 32'h1, 32'(pc.crystal_en));
		@(posedge pclk);
		level <= 2'h0;
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("warn wake", ev(EV_WARN), rd);
		enter_stop(32'h108);
		level <= 2'h2;
		wait_on(1, 1'b0);
		chk("pf regulator", 32'h0, 32'(pc.regulator_en));
		@(posedge pclk);
		level <= 2'h0;
		wait_on(1, 1'b1, 32'h9C40);
		chk("pf interval", 32'h1, 32'(n > 32'h7D00 && n < 32'h84D0));
		chk("pf boot", 32'h8000, 32'(pc.boot_addr));
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("pf status", 32'h1, 32'(rd[EV_PFRST]));
		apb(1'b1, OFF_CTRL, 32'h1);
		for (int s = 0; s < 2; s++) begin
			@(posedge pclk);
			if (s == 0) begin
				wdt_reset <= 1'b1;
			end else begin
				ext_reset_n <= 1'b0;
			end
			wait_on(1, 1'b0);
			chk("reset power", 32'h7, {29'h0, pc.regulator_en,
				pc.crystal_en, pc.monitor_en});
			@(posedge pclk);
			wdt_reset <= 1'b0;
			ext_reset_n <= 1'b1;
			wait_on(1, 1'b1);
			chk("release", 32'h1, 32'(n <= 20 + 2 * s));
			chk("boot", 32'h0, 32'(pc.boot_addr));
		end
		@(posedge pclk);
		level <= 2'h3;
		repeat (6) @(posedge pclk);
		#1;
		chk("por off", 32'h0, {27'h0, pc.regulator_en, pc.crystal_en,
			pc.monitor_en, pc.cpu_reset_n, pc.sram_retain});
		@(posedge pclk);
		level <= 2'h0;
		wait_on(1, 1'b1);
		chk("por boot", 32'h8000, 32'(pc.boot_addr));
		close_out();
	end

endmodule : stop_supervisor_tb_top

`default_nettype wire
